// ---- design/mis_delay_mem.sv ----
`timescale 1ns/1ns
// delay line: read data is the word written DEPTH cycles before, one cycle late
module mis_delay_mem #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 2750
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic [WIDTH-1:0] o_rd_data,
  output logic o_primed
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] ptr;
  logic [AW-1:0] next_ptr;
  logic primed;
  logic next_primed;
  logic rd_valid;
  logic next_rd_valid;

  // the word read at the wrap edge is itself still unwritten, so valid follows one edge later
  always_comb begin
    next_ptr = (ptr == LAST) ? '0 : ptr + AW'(1);
    next_primed = primed | (ptr == LAST);
    next_rd_valid = primed;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr <= '0;
      primed <= 1'b0;
      rd_valid <= 1'b0;
    end else begin
      ptr <= next_ptr;
      primed <= next_primed;
      rd_valid <= next_rd_valid;
    end
  end

  // array has no reset; primed hides its contents until the first wrap
  always_ff @(posedge i_clk) begin
    o_rd_data <= mem[ptr];
    mem[ptr] <= i_wr_data;
  end

  assign o_primed = rd_valid;
endmodule : mis_delay_mem

// ---- design/mis_pkg.sv ----
package mis_pkg;
  localparam logic [7:0] ADDR_STATUS_FIRST = 8'h41;
  localparam logic [7:0] ADDR_STATUS_SECOND = 8'h42;
  localparam logic [7:0] ADDR_TIMER_LIMIT = 8'h7a;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // first register fields
  localparam int FIRST_RAIL_LO = 0;
  localparam int FIRST_REMOTE_ONE = 4;
  localparam int FIRST_LOCAL = 5;
  localparam int FIRST_REMOTE_TWO = 6;
  localparam int FIRST_SUMMARY = 7;
  // second register fields
  localparam int SECOND_TWELVE_OR_IDENT = 0;
  localparam int SECOND_OVERTEMP = 1;
  localparam int SECOND_FAN_LO = 2;
  localparam int SECOND_FOURTH_FAN = 5;
  localparam int SECOND_DIODE_ONE = 6;
  localparam int SECOND_DIODE_TWO = 7;
  // identification change window
  localparam int CLK_PERIOD_PS = 4000;
  localparam int IDENT_WINDOW_US = 11;
  localparam int IDENT_WINDOW_CYC = (IDENT_WINDOW_US * 1000000) / CLK_PERIOD_PS;
  localparam int IDENT_WIDTH = 6;

  typedef enum logic [1:0] {
    MIS_PIN_TACH = 2'b00,
    MIS_PIN_GPIO_OUT = 2'b01,
    MIS_PIN_GPIO_IN = 2'b10,
    MIS_PIN_TIMER = 2'b11
  } mis_pin_mode_t;

  // measurements and limits, all from logic on the same clock
  typedef struct packed {
    logic [4:0][7:0] volt;
    logic [4:0][7:0] volt_lo;
    logic [4:0][7:0] volt_hi;
    logic [2:0][7:0] temp;
    logic [2:0][7:0] temp_lo;
    logic [2:0][7:0] temp_hi;
    logic [2:0][7:0] overtemp_limit;
    logic [2:0][7:0] overtemp_hysteresis;
    logic [3:0][15:0] tach;
    logic [3:0][15:0] tach_min;
    logic [7:0] timer_time;
    logic [7:0] timer_limit;
    logic [1:0] diode_fault;
    logic [2:0] pulse_off;
  } mis_meas_t;

  typedef struct packed {
    logic thermal_pin_timer;
    logic ident_six_mode;
    logic ident_alert_en;
    mis_pin_mode_t fourth_pin_mode;
  } mis_cfg_t;
endpackage : mis_pkg

// ---- design/mis_status.sv ----
`timescale 1ns/1ns
// Function
// - first status register is all zeros after power-on.
// - second status register is all zeros after power-on.
// - first register bits 0 to 3 flag the four rails out of limit.
// - a read clears a latched bit only when its fault is gone.
// - with the thermal pin as timer input, bit 0 flags timer limit exceeded.
// - first register bit 4 flags remote one temperature out of limit.
// - first register bit 5 flags local temperature out of limit.
// - first register bit 6 flags remote two temperature out of limit.
// - first register bit 7 is the OR of all second register bits.
// - second register bit 0 latches the twelve volt rail out of limit.
// - in identification mode bit 0 flags a code change over eleven microseconds.
// - an identification change may raise the alert output.
// - second register bit 1 flags any overtemperature limit exceeded.
// - overtemperature bit clears on read only below limit minus hysteresis.
// - second register bits 2 to 4 flag slow or stalled fans one to three.
// - a fan bit is not set while its pulse output is off.
// - as fourth tach, bit 5 flags fan four, suppressed when third pulse off.
// - as general output, writing bit 5 sets the pin level.
// - as general input, bit 5 reads the sampled pin level.
// - as timer input, bit 5 flags assertion time above the timer limit.
// - bits 6 and 7 flag open or short on diodes one and two.
// - high fault when reading above high limit, low fault at or below low.
// - fan fails when tach count exceeds minimum limit by at least one.
module mis_status (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  input wire logic i_wr_stb,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire mis_pkg::mis_meas_t i_meas,
  input wire mis_pkg::mis_cfg_t i_cfg,
  input wire logic [5:0] i_voltage_ident_code,
  input wire logic i_general_io_six,
  output logic o_general_io_six,
  output logic o_general_io_six_oe,
  output logic o_ident_alert
);
  function automatic logic out_of_limit(input logic [7:0] val, input logic [7:0] lo, input logic [7:0] hi);
    out_of_limit = (val > hi) || (val <= lo);
  endfunction : out_of_limit

  logic [7:0] status_first;
  logic [7:0] status_second;
  logic [7:0] next_status_first;
  logic [7:0] next_status_second;
  logic [7:0] set_first;
  logic [7:0] set_second;
  logic [7:0] hold_second;
  logic [7:0] view_second;
  logic [7:0] next_rd_data;
  logic gpio_level;
  logic next_gpio_level;
  logic rd_first;
  logic rd_second;
  logic timer_over;
  logic overtemp_set;
  logic overtemp_hold;
  logic ident_change;
  logic [5:0] ident_s1, ident_s2, ident_s3, ident_q;
  logic [5:0] next_ident_q;
  logic io_s1, io_s2, io_s3, io_q;
  logic next_io_q;
  logic [5:0] ident_past;
  logic ident_primed;

  // pin synchronisers; a level is taken once stages two and three agree
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      next_ident_q[i] = (ident_s2[i] == ident_s3[i]) ? ident_s3[i] : ident_q[i];
    end
    next_io_q = (io_s2 == io_s3) ? io_s3 : io_q;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ident_s1 <= '0;
      ident_s2 <= '0;
      ident_s3 <= '0;
      ident_q <= '0;
      io_s1 <= 1'b0;
      io_s2 <= 1'b0;
      io_s3 <= 1'b0;
      io_q <= 1'b0;
    end else begin
      ident_s1 <= i_voltage_ident_code;
      ident_s2 <= ident_s1;
      ident_s3 <= ident_s2;
      ident_q <= next_ident_q;
      io_s1 <= i_general_io_six;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      io_q <= next_io_q;
    end
  end

  mis_delay_mem #(
    .WIDTH(mis_pkg::IDENT_WIDTH),
    .DEPTH(mis_pkg::IDENT_WINDOW_CYC)
  ) u_ident_delay (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_wr_data(ident_q),
    .o_rd_data(ident_past),
    .o_primed(ident_primed)
  );

  // delay line output lags one cycle, so compare against the code one cycle old
  logic [5:0] ident_late;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ident_late <= '0;
    end else begin
      ident_late <= ident_q;
    end
  end

  // event sources
  always_comb begin
    rd_first = i_rd_stb && (i_rd_addr == mis_pkg::ADDR_STATUS_FIRST);
    rd_second = i_rd_stb && (i_rd_addr == mis_pkg::ADDR_STATUS_SECOND);
    timer_over = i_meas.timer_time > i_meas.timer_limit;
    ident_change = ident_primed && (ident_late != ident_past);
    overtemp_set = 1'b0;
    overtemp_hold = 1'b0;
    // widened sum: a hysteresis above the limit must not wrap and clear the bit early
    for (int i = 0; i < 3; i++) begin
      overtemp_set = overtemp_set | (i_meas.temp[i] > i_meas.overtemp_limit[i]);
      overtemp_hold = overtemp_hold |
        ({1'b0, i_meas.temp[i]} + {1'b0, i_meas.overtemp_hysteresis[i]} >= {1'b0, i_meas.overtemp_limit[i]});
    end
    set_first = '0;
    for (int i = 0; i < 4; i++) begin
      set_first[mis_pkg::FIRST_RAIL_LO + i] = out_of_limit(i_meas.volt[i], i_meas.volt_lo[i], i_meas.volt_hi[i]);
    end
    if (i_cfg.thermal_pin_timer) begin
      set_first[mis_pkg::FIRST_RAIL_LO] = timer_over;
    end
    set_first[mis_pkg::FIRST_REMOTE_ONE] = out_of_limit(i_meas.temp[0], i_meas.temp_lo[0], i_meas.temp_hi[0]);
    set_first[mis_pkg::FIRST_LOCAL] = out_of_limit(i_meas.temp[1], i_meas.temp_lo[1], i_meas.temp_hi[1]);
    set_first[mis_pkg::FIRST_REMOTE_TWO] = out_of_limit(i_meas.temp[2], i_meas.temp_lo[2], i_meas.temp_hi[2]);
    set_second = '0;
    set_second[mis_pkg::SECOND_TWELVE_OR_IDENT] = i_cfg.ident_six_mode ? ident_change :
      out_of_limit(i_meas.volt[4], i_meas.volt_lo[4], i_meas.volt_hi[4]);
    set_second[mis_pkg::SECOND_OVERTEMP] = overtemp_set;
    for (int i = 0; i < 3; i++) begin
      set_second[mis_pkg::SECOND_FAN_LO + i] = (i_meas.tach[i] > i_meas.tach_min[i]) && !i_meas.pulse_off[i];
    end
    unique case (i_cfg.fourth_pin_mode)
      mis_pkg::MIS_PIN_TACH: set_second[mis_pkg::SECOND_FOURTH_FAN] =
        (i_meas.tach[3] > i_meas.tach_min[3]) && !i_meas.pulse_off[2];
      mis_pkg::MIS_PIN_TIMER: set_second[mis_pkg::SECOND_FOURTH_FAN] = timer_over;
      mis_pkg::MIS_PIN_GPIO_OUT, mis_pkg::MIS_PIN_GPIO_IN: set_second[mis_pkg::SECOND_FOURTH_FAN] = 1'b0;
    endcase
    set_second[mis_pkg::SECOND_DIODE_ONE] = i_meas.diode_fault[0];
    set_second[mis_pkg::SECOND_DIODE_TWO] = i_meas.diode_fault[1];
    hold_second = set_second;
    hold_second[mis_pkg::SECOND_OVERTEMP] = overtemp_hold;
  end

  // read view: bit 5 carries the pin level in the general-purpose modes
  always_comb begin
    view_second = status_second;
    if (i_cfg.fourth_pin_mode == mis_pkg::MIS_PIN_GPIO_OUT) begin
      view_second[mis_pkg::SECOND_FOURTH_FAN] = gpio_level;
    end else if (i_cfg.fourth_pin_mode == mis_pkg::MIS_PIN_GPIO_IN) begin
      view_second[mis_pkg::SECOND_FOURTH_FAN] = io_q;
    end
  end

  // a present fault wins over the read clear, so no event is lost
  always_comb begin
    next_status_first = set_first | (status_first & ~({8{rd_first}} & ~set_first));
    next_status_first[mis_pkg::FIRST_SUMMARY] = 1'b0;
    next_status_second = set_second | (status_second & ~({8{rd_second}} & ~hold_second));
    next_gpio_level = gpio_level;
    if (i_wr_stb && i_wr_addr == mis_pkg::ADDR_STATUS_SECOND) begin
      next_gpio_level = i_wr_data[mis_pkg::SECOND_FOURTH_FAN];
    end
    next_rd_data = o_rd_data;
    if (rd_first) begin
      next_rd_data = {|view_second, status_first[6:0]};
    end else if (rd_second) begin
      next_rd_data = view_second;
    end else if (i_rd_stb) begin
      next_rd_data = 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_first <= mis_pkg::STATUS_RESET;
      status_second <= mis_pkg::STATUS_RESET;
      gpio_level <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      status_first <= next_status_first;
      status_second <= next_status_second;
      gpio_level <= next_gpio_level;
      o_rd_data <= next_rd_data;
    end
  end

  assign o_general_io_six = gpio_level;
  assign o_general_io_six_oe = (i_cfg.fourth_pin_mode == mis_pkg::MIS_PIN_GPIO_OUT);
  assign o_ident_alert = i_cfg.ident_six_mode && i_cfg.ident_alert_en &&
    status_second[mis_pkg::SECOND_TWELVE_OR_IDENT];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // reset checks look one edge on: the async event may race the first process start
  a_first_reset: assert property (@(posedge i_clk) disable iff (1'b0)
    !i_arst_n |=> status_first == mis_pkg::STATUS_RESET
  ) else $error("first status not clear in reset");
  a_second_reset: assert property (@(posedge i_clk) disable iff (1'b0)
    !i_arst_n |=> status_second == mis_pkg::STATUS_RESET
  ) else $error("second status not clear in reset");
  a_rail_sets: assert property (
    i_meas.volt[1] > i_meas.volt_hi[1] |=> status_first[1]
  ) else $error("rail event not latched");
  a_rail_low: assert property (
    !i_cfg.thermal_pin_timer && i_meas.volt[0] <= i_meas.volt_lo[0] |=> status_first[0]
  ) else $error("low limit equality missed");
  a_read_clears: assert property (
    rd_first && !set_first[2] |=> !status_first[2]
  ) else $error("subsided bit survived read");
  a_timer_first: assert property (
    i_cfg.thermal_pin_timer && i_meas.timer_time > i_meas.timer_limit |=> status_first[0]
  ) else $error("timer limit not flagged in first register");
  a_remote_one: assert property (
    i_meas.temp[0] > i_meas.temp_hi[0] |=> status_first[mis_pkg::FIRST_REMOTE_ONE]
  ) else $error("remote one temperature not flagged");
  a_local_low: assert property (
    i_meas.temp[1] <= i_meas.temp_lo[1] |=> status_first[mis_pkg::FIRST_LOCAL]
  ) else $error("local temperature not flagged");
  a_remote_two: assert property (
    i_meas.temp[2] > i_meas.temp_hi[2] |=> status_first[mis_pkg::FIRST_REMOTE_TWO]
  ) else $error("remote two temperature not flagged");
  a_summary_or: assert property (
    rd_first |=> o_rd_data[7] == $past(|view_second)
  ) else $error("summary bit wrong");
  a_twelve_volt: assert property (
    !i_cfg.ident_six_mode && i_meas.volt[4] > i_meas.volt_hi[4] |=> status_second[0]
  ) else $error("twelve volt rail not flagged");
  a_ident_change: assert property (
    i_cfg.ident_six_mode && ident_primed && ident_late != ident_past |=> status_second[0]
  ) else $error("ident change missed");
  a_alert_raise: assert property (
    i_cfg.ident_six_mode && i_cfg.ident_alert_en && status_second[0] |-> o_ident_alert
  ) else $error("alert not raised on ident change");
  a_overtemp_set: assert property (
    i_meas.temp[2] > i_meas.overtemp_limit[2] |=> status_second[1]
  ) else $error("overtemp not flagged");
  a_overtemp_hyst: assert property (
    rd_second && status_second[1] && overtemp_hold |=> status_second[1]
  ) else $error("overtemp cleared above hysteresis");
  a_fan_three: assert property (
    i_meas.tach[2] > i_meas.tach_min[2] && !i_meas.pulse_off[2] |=> status_second[4]
  ) else $error("fan three failure not flagged");
  a_fan_gate: assert property (
    i_meas.pulse_off[0] && !status_second[2] |=> !status_second[2]
  ) else $error("fan bit set with pulse off");
  a_fan_four: assert property (
    i_cfg.fourth_pin_mode == mis_pkg::MIS_PIN_TACH && i_meas.tach[3] > i_meas.tach_min[3]
    && !i_meas.pulse_off[2] |=> status_second[5]
  ) else $error("fan four failure not flagged");
  a_fan_four_gate: assert property (
    i_cfg.fourth_pin_mode == mis_pkg::MIS_PIN_TACH && i_meas.pulse_off[2] && !status_second[5] |=> !status_second[5]
  ) else $error("fan four bit set with third pulse off");
  a_gpio_drive: assert property (
    i_wr_stb && i_wr_addr == mis_pkg::ADDR_STATUS_SECOND && i_cfg.fourth_pin_mode == mis_pkg::MIS_PIN_GPIO_OUT
    |=> o_general_io_six == $past(i_wr_data[5])
  ) else $error("gpio level wrong");
  a_gpio_enable: assert property (
    i_cfg.fourth_pin_mode == mis_pkg::MIS_PIN_GPIO_OUT |-> o_general_io_six_oe
  ) else $error("gpio output not enabled");
  a_gpio_in_view: assert property (
    rd_second && i_cfg.fourth_pin_mode == mis_pkg::MIS_PIN_GPIO_IN |=> o_rd_data[5] == $past(io_q)
  ) else $error("gpio input level not returned");
  a_timer_fourth: assert property (
    i_cfg.fourth_pin_mode == mis_pkg::MIS_PIN_TIMER && i_meas.timer_time > i_meas.timer_limit |=> status_second[5]
  ) else $error("timer limit not flagged in second register");
  a_diode_two: assert property (
    i_meas.diode_fault[1] |=> status_second[mis_pkg::SECOND_DIODE_TWO]
  ) else $error("diode two fault not flagged");
  a_fan_min: assert property (
    i_meas.tach[1] <= i_meas.tach_min[1] && !status_second[3] |=> !status_second[3]
  ) else $error("fan flagged at its minimum limit");
  a_sticky_hold: assert property (
    status_first[6] && !rd_first |=> status_first[6]
  ) else $error("bit dropped without read");
  a_fault_keeps: assert property (
    rd_second && set_second[6] |=> status_second[6]
  ) else $error("present fault lost on read");

  c_read_clear: cover property (status_first[1] ##1 rd_first ##1 !status_first[1]);
  c_ident_alert: cover property ($rose(o_ident_alert));
  c_overtemp_kept: cover property (rd_second && status_second[1] && overtemp_hold && !overtemp_set);
  c_fan_gated: cover property (i_meas.pulse_off[0] && i_meas.tach[0] > i_meas.tach_min[0]);
  c_gpio_in_read: cover property (rd_second && i_cfg.fourth_pin_mode == mis_pkg::MIS_PIN_GPIO_IN && io_q);
endmodule : mis_status

// ---- test/mis_host.sv ----
`timescale 1ns/1ns
// host side of the status read path: one-cycle strobes launched at the falling edge
module mis_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rd_data,
  output logic o_rd_stb,
  output logic [7:0] o_rd_addr,
  output logic o_wr_stb,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data
);
  initial begin
    o_rd_stb = 1'b0;
    o_rd_addr = 8'h00;
    o_wr_stb = 1'b0;
    o_wr_addr = 8'h00;
    o_wr_data = 8'h00;
  end

  // data is taken one cycle after the strobe edge, when the answer has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_rd_stb = 1'b1;
    o_rd_addr = a;
    @(negedge i_clk);
    o_rd_stb = 1'b0;
    // address no longer qualified: invert it so a stale value cannot pass
    o_rd_addr = ~a;
    d = i_rd_data;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk);
    o_wr_stb = 1'b1;
    o_wr_addr = a;
    o_wr_data = v;
    @(negedge i_clk);
    o_wr_stb = 1'b0;
    o_wr_addr = ~a;
    o_wr_data = ~v;
  endtask : wr
endmodule : mis_host

// ---- test/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  logic clk;
  logic arst_n;
  logic rd_stb;
  logic wr_stb;
  logic [7:0] rd_addr;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  mis_pkg::mis_meas_t meas;
  mis_pkg::mis_meas_t base;
  mis_pkg::mis_cfg_t cfg;
  logic [5:0] ident;
  logic gpio_in;
  logic gpio_out;
  logic gpio_oe;
  logic alert;
  int bad_count = 0;
  int n_checks = 0;

  mis_status u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_rd_stb(rd_stb), .i_rd_addr(rd_addr),
    .o_rd_data(rd_data), .i_wr_stb(wr_stb), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .i_meas(meas), .i_cfg(cfg), .i_voltage_ident_code(ident), .i_general_io_six(gpio_in),
    .o_general_io_six(gpio_out), .o_general_io_six_oe(gpio_oe), .o_ident_alert(alert));

  mis_host u_host (.i_clk(clk), .i_rd_data(rd_data), .o_rd_stb(rd_stb), .o_rd_addr(rd_addr),
    .o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask : rc

  // hold the faulty value across exactly one rising edge, then restore
  task automatic blip();
    @(negedge clk);
    meas = base;
  endtask : blip

  task automatic test_done();
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  initial begin
    // whole run is under 4000 cycles; allow a wide margin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial begin
    arst_n = 1'b0;
    base = '0;
    for (int i = 0; i < 5; i++) begin
      base.volt[i] = 8'h80;
      base.volt_lo[i] = 8'h10;
      base.volt_hi[i] = 8'hf0;
    end
    for (int i = 0; i < 3; i++) begin
      base.temp[i] = 8'h40;
      base.temp_lo[i] = 8'h10;
      // high limit sits just under the overtemp limit, so a high excursion trips only its own bit
      base.temp_hi[i] = 8'h5f;
      base.overtemp_limit[i] = 8'h60;
      base.overtemp_hysteresis[i] = 8'h05;
    end
    for (int i = 0; i < 4; i++) begin
      base.tach[i] = 16'h0100;
      base.tach_min[i] = 16'h1000;
    end
    base.timer_limit = 8'h10;
    meas = base;
    cfg = '0;
    ident = 6'h00;
    gpio_in = 1'b0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    rc(mis_pkg::ADDR_STATUS_FIRST, 8'h00);
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h00);
    rc(8'h43, 8'h00);
    for (int i = 0; i < 4; i++) begin
      meas.volt[i] = base.volt_hi[i];
      rc(mis_pkg::ADDR_STATUS_FIRST, 8'h00);
      meas.volt[i] = base.volt_hi[i] + 8'h01;
      blip();
      rc(mis_pkg::ADDR_STATUS_FIRST, 8'h01 << i);
      rc(mis_pkg::ADDR_STATUS_FIRST, 8'h00);
      meas.volt[i] = base.volt_lo[i];
      rc(mis_pkg::ADDR_STATUS_FIRST, 8'h01 << i);
      rc(mis_pkg::ADDR_STATUS_FIRST, 8'h01 << i);
      meas = base;
      repeat (3) @(negedge clk);
      rc(mis_pkg::ADDR_STATUS_FIRST, 8'h01 << i);
      rc(mis_pkg::ADDR_STATUS_FIRST, 8'h00);
    end
    for (int k = 0; k < 3; k++) begin
      meas.temp[k] = base.temp_hi[k] + 8'h01;
      blip();
      rc(mis_pkg::ADDR_STATUS_FIRST, 8'h10 << k);
      rc(mis_pkg::ADDR_STATUS_FIRST, 8'h00);
    end
    meas.volt[4] = base.volt_lo[4] - 8'h01;
    blip();
    rc(mis_pkg::ADDR_STATUS_FIRST, 8'h80);
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h01);
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h00);
    base.temp[0] = 8'h5b;
    meas = base;
    meas.temp[0] = 8'h61;
    blip();
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h02);
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h02);
    base.temp[0] = 8'h5a;
    meas = base;
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h02);
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h00);
    rc(mis_pkg::ADDR_STATUS_FIRST, 8'h10);
    for (int f = 0; f < 4; f++) begin
      meas.tach[f] = base.tach_min[f];
      rc(mis_pkg::ADDR_STATUS_SECOND, 8'h00);
      meas.tach[f] = base.tach_min[f] + 16'h0001;
      meas.pulse_off[(f == 3) ? 2 : f] = 1'b1;
      rc(mis_pkg::ADDR_STATUS_SECOND, 8'h00);
      meas.pulse_off = 3'b000;
      blip();
      rc(mis_pkg::ADDR_STATUS_SECOND, 8'h04 << f);
      rc(mis_pkg::ADDR_STATUS_SECOND, 8'h00);
    end
    meas.diode_fault = 2'b11;
    blip();
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'hc0);
    cfg.fourth_pin_mode = mis_pkg::MIS_PIN_GPIO_OUT;
    u_host.wr(mis_pkg::ADDR_STATUS_SECOND, 8'h20);
    chk("gpio oe", {7'h00, gpio_oe}, 8'h01);
    chk("gpio out", {7'h00, gpio_out}, 8'h01);
    u_host.wr(mis_pkg::ADDR_STATUS_FIRST, 8'h00);
    chk("gpio out", {7'h00, gpio_out}, 8'h01);
    u_host.wr(mis_pkg::ADDR_STATUS_SECOND, 8'h00);
    chk("gpio out", {7'h00, gpio_out}, 8'h00);
    cfg.fourth_pin_mode = mis_pkg::MIS_PIN_GPIO_IN;
    gpio_in = 1'b1;
    repeat (6) @(negedge clk);
    chk("gpio oe", {7'h00, gpio_oe}, 8'h00);
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h20);
    gpio_in = 1'b0;
    repeat (6) @(negedge clk);
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h00);
    cfg.fourth_pin_mode = mis_pkg::MIS_PIN_TIMER;
    meas.timer_time = base.timer_limit;
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h00);
    meas.timer_time = base.timer_limit + 8'h01;
    blip();
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h20);
    cfg.fourth_pin_mode = mis_pkg::MIS_PIN_TACH;
    cfg.thermal_pin_timer = 1'b1;
    meas.timer_time = base.timer_limit + 8'h01;
    blip();
    rc(mis_pkg::ADDR_STATUS_FIRST, 8'h01);
    cfg.thermal_pin_timer = 1'b0;
    cfg.ident_six_mode = 1'b1;
    cfg.ident_alert_en = 1'b1;
    // the change detector needs its delay line primed first
    repeat (2800) @(negedge clk);
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h00);
    ident = 6'h2a;
    repeat (10) @(negedge clk);
    chk("alert", {7'h00, alert}, 8'h01);
    rc(mis_pkg::ADDR_STATUS_SECOND, 8'h01);
    cfg.ident_alert_en = 1'b0;
    repeat (2) @(negedge clk);
    chk("alert", {7'h00, alert}, 8'h00);
    test_done();
  end
endmodule : testbench
